// ---- rtl/gpm_regs.svh ----
// Notes on behaviour
// - four-bit mode field per pin, two registers per port
// - all mode fields reset to floating input
// - analog mode; input data reads one
// - modes 1/5 drive output data push-pull/open-drain
// - mode 8 pulls by output data bit
// - mode 9 drives peripheral value push-pull
// - mode D drives peripheral value open-drain
// - mode B is SPI master clock output
// - reset forces boot select pin pulled up
// - JTAG forces reset, data-in, mode-select pulled up
// - JTAG forces test data out push-pull
// - serial-wire debugger owns the data pin direction
// - timer B channels on A0-3 or B1-4
// - open-drain one floats; push-pull one sources
// - output modes: no pulls, input stays readable
`ifndef GPM_REGS_SVH
`define GPM_REGS_SVH

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define GPM_PA_MODE_LO_OFF 16'hB000
`define GPM_PA_MODE_HI_OFF 16'hB004
`define GPM_PB_MODE_LO_OFF 16'hB400
`define GPM_PB_MODE_HI_OFF 16'hB404
`define GPM_PC_MODE_LO_OFF 16'hB800
`define GPM_PC_MODE_HI_OFF 16'hB804
`define GPM_CTRL_OFF       16'hBC40
`define GPM_STAT_OFF       16'hBC44

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define GPM_MODE_RST       16'h4444
`define GPM_MODE_W         4
`define GPM_FIELDS_PER_REG 4
`define GPM_CTRL_REMAP_BIT 0
`define GPM_STAT_JTAG_BIT  0
`define GPM_STAT_SWD_BIT   1
`define GPM_STAT_REMAP_BIT 2
// pad control {out, oe, pu, pd, ana} while reset is held
`define GPM_PAD_BOOT_RST   5'b00100
`define GPM_PAD_IDLE       5'b00000

// ----------------------------------------------------------------
// pin indices: port a 0-7, port b 8-15, port c 16-23
// ----------------------------------------------------------------
`define GPM_PIN_BOOT       5
`define GPM_PIN_TRST       16
`define GPM_PIN_TDO        18
`define GPM_PIN_TDI        19
`define GPM_PIN_TMS        20
`define GPM_PIN_SWDIO      20
`define GPM_PIN_A0         5'h00
`define GPM_PIN_A1         5'h01
`define GPM_PIN_A2         5'h02
`define GPM_PIN_A3         5'h03
`define GPM_PIN_B1         5'h09
`define GPM_PIN_B2         5'h0A
`define GPM_PIN_B3         5'h0B
`define GPM_PIN_B4         5'h0C

`endif

// ---- rtl/gpm_pkg.sv ----
package gpm_pkg;

  // pin mode encodings held in each four-bit field
  typedef enum logic [3:0] {
    GPM_MODE_ANALOG   = 4'h0,
    GPM_MODE_OUT_PP   = 4'h1,
    GPM_MODE_FLOAT    = 4'h4,
    GPM_MODE_OUT_OD   = 4'h5,
    GPM_MODE_PULLED   = 4'h8,
    GPM_MODE_ALT_PP   = 4'h9,
    GPM_MODE_ALT_SCLK = 4'hB,
    GPM_MODE_ALT_OD   = 4'hD
  } gpm_mode_t;

  // pad control for one pin
  typedef struct packed {
    logic out;   // level driven while oe is high
    logic oe;    // output driver enabled
    logic pu;    // pull-up resistor enabled
    logic pd;    // pull-down resistor enabled
    logic ana;   // analog: digital input path cut off
  } gpm_pad_ctl_t;

  // debug port request from the debug logic
  typedef struct packed {
    logic jtag;      // jtag debug mode active
    logic swd;       // serial-wire debug mode active
    logic swd_drive; // debugger drives the serial-wire data pin
    logic swd_out;   // serial-wire data level
    logic tdo;       // test data out level
  } gpm_dbg_t;

endpackage

// ---- rtl/gpm_pin_cell.sv ----
`timescale 1ns/100ps
module gpm_pin_cell (
  input  wire gpm_pkg::gpm_mode_t    mode,
  input  wire logic                  out_data,
  input  wire logic                  alt_data,
  output      gpm_pkg::gpm_pad_ctl_t ctl
);
  import gpm_pkg::*;

  // ----------------------------------------------------------------
  // mode decode, purely combinational
  // ----------------------------------------------------------------
  // open-drain never drives high: the driver is simply released
  always_comb begin
    ctl = '0;
    unique case (mode)
      GPM_MODE_ANALOG: begin
        ctl.ana = 1'b1;
      end
      GPM_MODE_OUT_PP: begin
        ctl.oe  = 1'b1;
        ctl.out = out_data;
      end
      GPM_MODE_FLOAT: begin
        ctl = '0;
      end
      GPM_MODE_OUT_OD: begin
        ctl.oe  = ~out_data;
        ctl.out = 1'b0;
      end
      GPM_MODE_PULLED: begin
        ctl.pu = out_data;
        ctl.pd = ~out_data;
      end
      GPM_MODE_ALT_PP, GPM_MODE_ALT_SCLK: begin
        ctl.oe  = 1'b1;
        ctl.out = alt_data;
      end
      GPM_MODE_ALT_OD: begin
        ctl.oe  = ~alt_data;
        ctl.out = 1'b0;
      end
      default: begin
        ctl = '0;
      end
    endcase
  end

endmodule

// ---- rtl/gpm_top.sv ----
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
`include "gpm_regs.svh"
module gpm_top #(
  parameter int ADDR_W   = 16,
  parameter int NUM_PINS = 24,
  parameter int NUM_CH   = 4
) (
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_W-1:0]     paddr,
  input  wire logic [31:0]           pwdata,
  output      logic [31:0]           prdata_q,
  output      logic                  pready_q,
  output      logic                  pslverr_q,
  // port output data register held outside this block; input data is registered here
  input  wire logic [NUM_PINS-1:0]   port_output_data,
  output      logic [NUM_PINS-1:0]   port_input_data_q,
  // peripheral alternate outputs, one per pin
  input  wire logic [NUM_PINS-1:0]   periph_alt_out,
  // timer b channels
  input  wire logic [NUM_CH-1:0]     timer_b_out,
  input  wire logic [NUM_CH-1:0]     timer_b_out_en,
  output      logic [NUM_CH-1:0]     timer_b_capture_q,
  // debug port
  input  wire gpm_pkg::gpm_dbg_t     dbg,
  // pads
  input  wire logic [NUM_PINS-1:0]   pad_in,
  output      gpm_pkg::gpm_pad_ctl_t pad_ctl_q [NUM_PINS]
);
  import gpm_pkg::*;

  localparam int NUM_REGS = NUM_PINS / `GPM_FIELDS_PER_REG;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0]         cfg_q [NUM_REGS];
  logic                remap_q;
  logic                wr_go;
  logic                rd_go;
  logic [31:0]         rd_data;
  logic                rd_err;
  logic [2:0]          cfg_idx;
  logic                cfg_hit;
  logic [NUM_PINS-1:0] in_view;
  logic [NUM_PINS-1:0] tmr_sel;
  logic [NUM_PINS-1:0] tmr_val;
  logic [NUM_CH-1:0]   cap_d;

  // default and remapped pins of each timer channel, channel 1 first
  localparam logic [4:0] PIN_DEF [4] = '{`GPM_PIN_A0, `GPM_PIN_A3, `GPM_PIN_A1, `GPM_PIN_A2};
  localparam logic [4:0] PIN_RMP [4] = '{`GPM_PIN_B1, `GPM_PIN_B2, `GPM_PIN_B3, `GPM_PIN_B4};

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // one wait state: the first access cycle prepares the answer,
  // the second carries pready, and a write lands on that edge
  assign rd_go = psel & penable & ~pready_q;
  assign wr_go = psel & penable & pready_q & pwrite;

  // map an address onto one of the six mode registers
  always_comb begin
    cfg_hit = 1'b1;
    cfg_idx = 3'h0;
    unique case (paddr)
      `GPM_PA_MODE_LO_OFF: cfg_idx = 3'h0;
      `GPM_PA_MODE_HI_OFF: cfg_idx = 3'h1;
      `GPM_PB_MODE_LO_OFF: cfg_idx = 3'h2;
      `GPM_PB_MODE_HI_OFF: cfg_idx = 3'h3;
      `GPM_PC_MODE_LO_OFF: cfg_idx = 3'h4;
      `GPM_PC_MODE_HI_OFF: cfg_idx = 3'h5;
      default: begin
        cfg_hit = 1'b0;
      end
    endcase
  end

  // read mux; reserved upper bits read as zero
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    if (cfg_hit) begin
      rd_data[15:0] = cfg_q[cfg_idx];
    end else if (paddr == `GPM_CTRL_OFF) begin
      rd_data[`GPM_CTRL_REMAP_BIT] = remap_q;
    end else if (paddr == `GPM_STAT_OFF) begin
      rd_data[`GPM_STAT_JTAG_BIT]  = dbg.jtag;
      rd_data[`GPM_STAT_SWD_BIT]   = dbg.swd;
      rd_data[`GPM_STAT_REMAP_BIT] = remap_q;
    end else begin
      rd_err = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // apb answer
  // ----------------------------------------------------------------
  // answer flops; an unmapped address errors and reads zero
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= rd_go;
      pslverr_q <= rd_go & rd_err;
      if (rd_go & ~pwrite) begin
        prdata_q <= rd_data;
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // mode registers
  // ----------------------------------------------------------------
  // only the low half is stored; any code is kept as written
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int r = 0; r < NUM_REGS; r++) begin
        cfg_q[r] <= `GPM_MODE_RST;
      end
    end else if (wr_go && cfg_hit) begin
      cfg_q[cfg_idx] <= pwdata[15:0];
    end
  end

  // control register: timer b placement
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      remap_q <= 1'b0;
    end else if (wr_go && paddr == `GPM_CTRL_OFF) begin
      remap_q <= pwdata[`GPM_CTRL_REMAP_BIT];
    end
  end

  // ----------------------------------------------------------------
  // timer b routing
  // ----------------------------------------------------------------
  // each channel claims one pin; capture and output follow the same pin
  always_comb begin
    tmr_sel = '0;
    tmr_val = '0;
    cap_d   = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      if (remap_q) begin
        tmr_sel[PIN_RMP[c]] = timer_b_out_en[c];
        tmr_val[PIN_RMP[c]] = timer_b_out[c];
        cap_d[c]            = in_view[PIN_RMP[c]];
      end else begin
        tmr_sel[PIN_DEF[c]] = timer_b_out_en[c];
        tmr_val[PIN_DEF[c]] = timer_b_out[c];
        cap_d[c]            = in_view[PIN_DEF[c]];
      end
    end
  end

  // capture inputs seen by the timer, one cycle behind the pad
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      timer_b_capture_q <= '0;
    end else begin
      timer_b_capture_q <= cap_d;
    end
  end

  // ----------------------------------------------------------------
  // per-pin mode, overrides and pad flops
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    gpm_mode_t    eff_mode;
    logic         eff_out;
    logic         eff_alt;
    gpm_pad_ctl_t ctl_d;
    // field position of this pin inside its mode register
    localparam int REG_IX = i / `GPM_FIELDS_PER_REG;
    localparam int FLD_LO = (i % `GPM_FIELDS_PER_REG) * `GPM_MODE_W;

    // the input path stays live in every digital mode; analog reads one
    assign in_view[i] = pad_ctl_q[i].ana ? 1'b1 : pad_in[i];

    // debug overrides replace the stored mode without touching it
    always_comb begin
      eff_mode = gpm_mode_t'(cfg_q[REG_IX][FLD_LO +: `GPM_MODE_W]);
      eff_out  = port_output_data[i];
      eff_alt  = tmr_sel[i] ? tmr_val[i] : periph_alt_out[i];
      if (dbg.jtag && (i == `GPM_PIN_TRST || i == `GPM_PIN_TDI || i == `GPM_PIN_TMS)) begin
        eff_mode = GPM_MODE_PULLED;
        eff_out  = 1'b1;
      end else if (dbg.jtag && i == `GPM_PIN_TDO) begin
        eff_mode = GPM_MODE_ALT_PP;
        eff_alt  = dbg.tdo;
      end else if (dbg.swd && i == `GPM_PIN_SWDIO) begin
        eff_mode = dbg.swd_drive ? GPM_MODE_ALT_PP : GPM_MODE_FLOAT;
        eff_alt  = dbg.swd_out;
      end
    end

    gpm_pin_cell u_cell (
      .mode     (eff_mode),
      .out_data (eff_out),
      .alt_data (eff_alt),
      .ctl      (ctl_d)
    );

    // pad control flops; during reset every pin floats except the
    // boot select pin, which is held pulled up so the strap reads true
    always_ff @(posedge mclk) begin
      if (sys_rst) begin
        pad_ctl_q[i] <= (i == `GPM_PIN_BOOT) ? `GPM_PAD_BOOT_RST : `GPM_PAD_IDLE;
      end else begin
        pad_ctl_q[i] <= ctl_d;
      end
    end

    // input data as software sees it
    always_ff @(posedge mclk) begin
      if (sys_rst) begin
        port_input_data_q[i] <= 1'b0;
      end else begin
        port_input_data_q[i] <= in_view[i];
      end
    end
  end

endmodule

// ---- verif/gpm_top_asserts.sv ----
`timescale 1ns/100ps
`include "gpm_regs.svh"
module gpm_top_asserts #(
  parameter int NUM_PINS = 24
) (
  input wire logic                  mclk,
  input wire logic                  sys_rst,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic [31:0]           prdata_q,
  input wire logic                  pready_q,
  input wire logic                  pslverr_q,
  input wire logic [NUM_PINS-1:0]   port_input_data_q,
  input wire gpm_pkg::gpm_dbg_t     dbg,
  input wire gpm_pkg::gpm_pad_ctl_t pad_ctl_q [NUM_PINS]
);
  import gpm_pkg::*;
  // -----------------
  // bus and pad checks
  // -----------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence s_first_access;
    psel && penable && !pready_q;
  endsequence
  sequence s_answer;
    pready_q ##1 !pready_q;
  endsequence
  a_one_wait_state: assert property (s_first_access |=> s_answer)
    else $error("ready not one cycle after access");
  a_err_with_ready: assert property (pslverr_q |-> pready_q)
    else $error("error without ready");
  a_rdata_idle_zero: assert property (!pready_q |-> prdata_q == 32'h0)
    else $error("read data outside answer");
  // boot pin is judged while reset is high, so no disable here
  a_boot_pull_up: assert property (disable iff (1'b0) sys_rst |=>
    pad_ctl_q[`GPM_PIN_BOOT] == 5'b00100) else $error("boot pin not pulled up");
  a_jtag_tdo_drive: assert property ($past(dbg.jtag) && !$past(sys_rst) |->
    pad_ctl_q[18].oe && pad_ctl_q[18].out == $past(dbg.tdo)) else $error("tdo not driven");
  a_jtag_pin_pulls: assert property ($past(dbg.jtag) && !$past(sys_rst) |->
    pad_ctl_q[16].pu && pad_ctl_q[19].pu && pad_ctl_q[20].pu) else $error("jtag pull missing");
  for (genvar k = 0; k < NUM_PINS; k++) begin : g_pin
    a_drive_no_pull: assert property (pad_ctl_q[k].oe |-> !pad_ctl_q[k].pu)
      else $error("pull left on while driving");
    a_pull_single: assert property (!(pad_ctl_q[k].pu && pad_ctl_q[k].pd))
      else $error("both pulls on");
    a_idle_out_low: assert property (!pad_ctl_q[k].oe |-> !pad_ctl_q[k].out)
      else $error("level set with driver off");
    a_analog_reads_one: assert property (pad_ctl_q[k].ana && $past(pad_ctl_q[k].ana)
      |-> port_input_data_q[k] && pad_ctl_q[k] == 5'b00001) else $error("analog pin wrong");
  end
endmodule
bind gpm_top gpm_top_asserts #(.NUM_PINS(NUM_PINS)) i_gpm_top_asserts (.mclk(mclk),
  .sys_rst(sys_rst), .psel(psel), .penable(penable), .prdata_q(prdata_q),
  .pready_q(pready_q), .pslverr_q(pslverr_q), .port_input_data_q(port_input_data_q),
  .dbg(dbg), .pad_ctl_q(pad_ctl_q));

// ---- verif/gpm_pad_model.sv ----
`timescale 1ns/100ps
module gpm_pad_model (
  input  wire logic                  mclk,
  input  wire gpm_pkg::gpm_pad_ctl_t pad_ctl_q [24],
  output      logic [23:0]           pad_in
);
  import gpm_pkg::*;
  logic [23:0] noise_q = 24'h5A5A5A;
  // a floating pin wanders each cycle, so no level is read by luck
  always_ff @(posedge mclk) begin
    noise_q <= ~noise_q ^ {noise_q[22:0], 1'b0};
  end
  // driver wins, then pulls, else the wire floats
  always_comb begin
    for (int k = 0; k < 24; k++) begin
      if (pad_ctl_q[k].oe) pad_in[k] = pad_ctl_q[k].out;
      else if (pad_ctl_q[k].pu) pad_in[k] = 1'b1;
      else if (pad_ctl_q[k].pd) pad_in[k] = 1'b0;
      else pad_in[k] = noise_q[k];
    end
  end
endmodule

// ---- verif/test_gpio_pin_mode_config.sv ----
`timescale 1ns/100ps
`include "gpm_regs.svh"
module test_gpio_pin_mode_config;
  import gpm_pkg::*;
  localparam logic [15:0] ADDRS [6] = '{`GPM_PA_MODE_LO_OFF, `GPM_PA_MODE_HI_OFF,
    `GPM_PB_MODE_LO_OFF, `GPM_PB_MODE_HI_OFF, `GPM_PC_MODE_LO_OFF, `GPM_PC_MODE_HI_OFF};
  localparam logic [3:0]  MODES [9] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hB, 4'hD, 4'h3};
  localparam int          TPIN  [4] = '{0, 3, 1, 2};
  logic         mclk, sys_rst, psel, penable, pwrite, pready_q, pslverr_q, er;
  logic [15:0]  paddr;
  logic [31:0]  pwdata, prdata_q, rd, v;
  logic [23:0]  out_data, in_data, alt_out, pad_in;
  logic [3:0]   t_out, t_en, cap;
  logic [4:0]   e;
  gpm_dbg_t     dbg;
  gpm_pad_ctl_t pad [24];
  int           mismatches, cmp_count;
  gpm_top i_gpm_top (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
    .pready_q(pready_q), .pslverr_q(pslverr_q), .port_output_data(out_data),
    .port_input_data_q(in_data), .periph_alt_out(alt_out), .timer_b_out(t_out),
    .timer_b_out_en(t_en), .timer_b_capture_q(cap), .dbg(dbg), .pad_in(pad_in),
    .pad_ctl_q(pad));
  gpm_pad_model i_gpm_pad_model (.mclk(mclk), .pad_ctl_q(pad), .pad_in(pad_in));
  // -----------------
  // clock, checks, bus
  // -----------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: word %h, want %h", $time, got, exp);
    end
  endtask
  task automatic chk_pad(input gpm_pad_ctl_t got, input logic [4:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: pad %b, want %b", $time, got, exp);
    end
  endtask
  // request held until ready is seen high at an edge
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] wd);
    int n;
    @(posedge mclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, wd};
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready_q !== 1'b1 && n < 20);
    rd = prdata_q;
    er = pslverr_q;
    chk_word({31'h0, pready_q}, 32'h1);
    {psel, penable} <= 2'b00;
  endtask
  // expected pad control {out, oe, pu, pd, ana}
  function automatic logic [4:0] exp_pad(logic [3:0] m, logic od, logic alt);
    case (m)
      4'h0: return 5'b00001;
      4'h1: return {od, 4'b1000};
      4'h5: return {1'b0, ~od, 3'b000};
      4'h8: return {2'b00, od, ~od, 1'b0};
      4'h9, 4'hB: return {alt, 4'b1000};
      4'hD: return {1'b0, ~alt, 3'b000};
      default: return 5'b00000;
    endcase
  endfunction
  // -----------------
  // scenarios
  // -----------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, out_data, alt_out, t_out, t_en} = '0;
    dbg = '0;
    sys_rst = 1'b1;
    v = $urandom(99);
    repeat (10) @(posedge mclk);
    chk_pad(pad[`GPM_PIN_BOOT], 5'b00100);
    sys_rst <= 1'b0;
    foreach (ADDRS[i]) begin
      apb(1'b0, ADDRS[i], 32'h0);
      chk_word(rd, 32'h4444);
    end
    chk_pad(pad[`GPM_PIN_BOOT], 5'b00000);
    apb(1'b0, 16'hB008, 32'h0);
    chk_word({er, rd[30:0]}, 32'h80000000);
    // random contents and back-to-back readback; upper half is reserved
    foreach (ADDRS[i]) begin
      v = $urandom;
      apb(1'b1, ADDRS[i], v);
      apb(1'b0, ADDRS[i], 32'h0);
      chk_word(rd, {16'h0, v[15:0]});
    end
    // every mode code on pb3, the spi clock pin
    foreach (MODES[i]) begin
      v = $urandom;
      out_data <= v[23:0];
      alt_out <= v[31:8];
      apb(1'b1, `GPM_PB_MODE_LO_OFF, (MODES[i] == 4'hB) ? 32'hB444 : {4{MODES[i]}});
      repeat (3) @(posedge mclk);
      e = exp_pad(MODES[i], out_data[11], alt_out[11]);
      chk_pad(pad[11], e);
      if (e[3:0] != 4'h0) chk_word(in_data[11], e[0] | (e[3] ? e[4] : e[2]));
    end
    // timer channels, remapped then default
    t_en <= 4'hF;
    t_out <= v[3:0];
    apb(1'b1, `GPM_PB_MODE_LO_OFF, 32'h9994);
    apb(1'b1, `GPM_PB_MODE_HI_OFF, 32'h4449);
    apb(1'b1, `GPM_PA_MODE_LO_OFF, 32'h9999);
    apb(1'b1, `GPM_CTRL_OFF, 32'h1);
    apb(1'b0, `GPM_STAT_OFF, 32'h0);
    chk_word(rd, 32'h4);
    repeat (4) @(posedge mclk);
    for (int c = 0; c < 4; c++) chk_word(pad[9 + c].out, t_out[c]);
    chk_word(cap, t_out);
    apb(1'b1, `GPM_CTRL_OFF, 32'h0);
    repeat (4) @(posedge mclk);
    for (int c = 0; c < 4; c++) chk_word(pad[TPIN[c]].out, t_out[c]);
    chk_word(cap, t_out);
    // debug overrides over analog port c
    apb(1'b1, `GPM_PC_MODE_LO_OFF, 32'h0);
    apb(1'b1, `GPM_PC_MODE_HI_OFF, 32'h0);
    dbg <= {4'b1000, v[0]};
    repeat (3) @(posedge mclk);
    chk_pad(pad[16], 5'b00100);
    chk_pad(pad[19], 5'b00100);
    chk_pad(pad[20], 5'b00100);
    chk_pad(pad[18], {v[0], 4'b1000});
    for (int d = 0; d < 2; d++) begin
      dbg <= {2'b01, d[0], v[2], 1'b0};
      repeat (3) @(posedge mclk);
      chk_pad(pad[20], d[0] ? {v[2], 4'b1000} : 5'b00000);
    end
    // reset mid-run while the boot pin drives: reset must still pull it up
    apb(1'b1, `GPM_PA_MODE_HI_OFF, 32'h4414);
    repeat (2) @(posedge mclk);
    chk_pad(pad[`GPM_PIN_BOOT], {out_data[5], 4'b1000});
    sys_rst <= 1'b1;
    dbg <= '0;
    repeat (2) @(posedge mclk);
    chk_pad(pad[`GPM_PIN_BOOT], 5'b00100);
    sys_rst <= 1'b0;
    apb(1'b0, `GPM_PA_MODE_HI_OFF, 32'h0);
    chk_word(rd, 32'h4444);
    tally_and_finish();
  end
  // cut a hang short
  initial begin
    #80000;
    mismatches++;
    tally_and_finish();
  end
endmodule
